/* File: core/cmd_word_mem.sv */
// Indexed command object word store with registered read data.
`timescale 1ns/1ps
module cmd_word_mem
(
    // Clock, reset and clock enable.
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Write port.
    input wire logic wr_i,
    input wire logic [2:0] waddr_i,
    input wire logic [15:0] wdata_i,
    // Read port.
    input wire logic [2:0] raddr_i,
    output logic [15:0] rdata_o
);
    logic [15:0] mem_q [0:7];

    always_ff @(posedge clk_i)
    begin
        if (ce_i && wr_i)
        begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rdata_o <= 16'h0000;
        end
        else if (ce_i)
        begin
            rdata_o <= mem_q[raddr_i];
        end
    end
endmodule

/* File: core/dflash_command_sequencer.sv */
// Data flash command sequencer with register port and array handshake.
//
// Function
// - Field margin command sets margin, special mode only.
// - Field margin: index, block, level errors; access_error_flag only.
// - Unavailable command raises access_error_flag and does not run.
// - Section verify checks erased range, then sets complete.
// - Section verify needs command index two at launch.
// - Section verify: bad, odd or overrunning range errs.
// - Section verify read errors set verify status bits.
// - Program word count from index, then verify them.
// - Program index outside two to five raises access_error_flag.
// - Program: bad, odd or overrunning address errs.
// - Protected program area sets protection flag, no write.
// - Program and erase verify set verify status bits.
// - Sector erase erases, verifies, completes; index one.
// - Sector erase: bad or odd address, protection flag.
`timescale 1ns/1ps
`include "dflash_map.svh"
module dflash_command_sequencer
(
    // Clock, reset and clock enable.
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Register port.
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    // Interrupt.
    output logic irq_o,
    // Flash array handshake.
    output dflash_pkg::arr_cmd_t arr_cmd_o,
    input wire dflash_pkg::arr_rsp_t arr_rsp_i,
    // Read margin levels.
    output logic [2:0] df_margin_o,
    output logic [2:0] pf_margin_o
);
    import dflash_pkg::*;

    state_t state_q;
    logic [2:0] idx_q;
    logic [1:0] cfg_q;
    logic [15:0] prot_q;
    logic [2:0] mask_q;
    logic [2:0] irq_stat_q;
    logic command_complete_flag_q;
    logic access_error_flag_q;
    logic protection_violation_flag_q;
    logic vs1_q;
    logic vs0_q;
    logic [15:0] w_q [0:2];
    logic [1:0] fcnt_q;
    logic [15:0] addr_q;
    logic [15:0] base_q;
    logic [15:0] left_q;
    logic [1:0] widx_q;
    logic vfy_q;
    logic [15:0] mem_rdata;
    logic [2:0] mem_raddr;
    logic wr_stat;
    logic launch;
    logic [7:0] cmd;
    logic [1:0] blk;
    logic [15:0] a16;
    logic [2:0] nprog;
    logic ok_addr;
    logic chk_acc;
    logic prot_c;
    logic vrd_ack;
    logic [15:0] expect_w;
    logic set_vs1;
    logic set_vs0;
    logic [2:0] irq_set;
    logic [15:0] rd_mux;

    ////////////////////////////////////////////////////////////////////////
    // Range and protection arithmetic.

    function automatic logic fits(input logic [15:0] a,
                                  input logic [16:0] nbytes);
        return ({2'h0, a} + {1'h0, nbytes}) <= {1'h0, `DF_BYTES};
    endfunction

    function automatic logic prot_hit(input logic [15:0] a,
                                      input logic [16:0] nbytes,
                                      input logic [15:0] start);
        return ({2'h0, a} + {1'h0, nbytes}) > {2'h0, start};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Command word store.

    assign mem_raddr = (state_q == S_FETCH) ? {1'b0, fcnt_q}
                                            : (`IDX_DATA0 + {1'b0, widx_q});

    cmd_word_mem u_words (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .wr_i(reg_wr_i && reg_addr_i == `REG_OBJECT && command_complete_flag_q),
        .waddr_i(idx_q),
        .wdata_i(reg_wdata_i),
        .raddr_i(mem_raddr),
        .rdata_o(mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Launch and parameter checks.

    assign wr_stat = reg_wr_i && reg_addr_i == `REG_STAT;
    assign launch = wr_stat && reg_wdata_i[`STAT_COMMAND_COMPLETE_FLAG] && command_complete_flag_q &&
                    !(access_error_flag_q && !reg_wdata_i[`STAT_ACC]) &&
                    !(protection_violation_flag_q && !reg_wdata_i[`STAT_FPV]);
    assign cmd = w_q[0][15:8];
    assign blk = w_q[0][1:0];
    assign a16 = w_q[1];
    assign nprog = idx_q - 3'h1;
    assign ok_addr = blk == `DF_BLK && {1'b0, a16} < `DF_BYTES;

    always_comb
    begin
        chk_acc = 1'b0;
        prot_c = 1'b0;
        unique case (cmd)
            `CMD_FMARGIN:
            begin
                chk_acc = !cfg_q[`CFG_SPECIAL] || idx_q != `IDX_FMARGIN ||
                          !(blk == `DF_BLK || blk == `PF_BLK) ||
                          a16 > `MARGIN_MAX;
            end
            `CMD_SEVERIFY:
            begin
                chk_acc = cfg_q[`CFG_SECURE] || idx_q != `IDX_SEVERIFY ||
                          !ok_addr || a16[0] || w_q[2] == 16'h0000 ||
                          !fits(a16, {w_q[2], 1'b0});
            end
            `CMD_PROGRAM:
            begin
                chk_acc = cfg_q[`CFG_SECURE] || idx_q < `IDX_PROG_MIN ||
                          idx_q > `IDX_PROG_MAX || !ok_addr || a16[0] ||
                          !fits(a16, {13'h0000, nprog, 1'b0});
                prot_c = prot_hit(a16, {13'h0000, nprog, 1'b0},
                                  prot_q);
            end
            `CMD_ERASE:
            begin
                chk_acc = cfg_q[`CFG_SECURE] || idx_q != `IDX_ERASE ||
                          !ok_addr || a16[0];
                prot_c = prot_hit(a16 & `SECTOR_MASK, `SECTOR_BYTES,
                                  prot_q);
            end
            default:
            begin
                chk_acc = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer.

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= S_IDLE;
            fcnt_q <= 2'h0;
            w_q[0] <= 16'h0000;
            w_q[1] <= 16'h0000;
            w_q[2] <= 16'h0000;
            addr_q <= 16'h0000;
            base_q <= 16'h0000;
            left_q <= 16'h0000;
            widx_q <= 2'h0;
            vfy_q <= 1'b0;
        end
        else if (ce_i)
        begin
            unique case (state_q)
                S_IDLE:
                begin
                    fcnt_q <= 2'h0;
                    widx_q <= 2'h0;
                    vfy_q <= 1'b0;
                    if (launch)
                    begin
                        state_q <= S_FETCH;
                    end
                end
                S_FETCH:
                begin
                    fcnt_q <= fcnt_q + 2'h1;
                    if (fcnt_q != 2'h0)
                    begin
                        w_q[fcnt_q - 2'h1] <= mem_rdata;
                    end
                    if (fcnt_q == 2'h3)
                    begin
                        state_q <= S_CHECK;
                    end
                end
                S_CHECK:
                begin
                    addr_q <= a16;
                    base_q <= a16;
                    left_q <= w_q[2];
                    if (chk_acc || prot_c || cmd == `CMD_FMARGIN)
                    begin
                        state_q <= S_DONE;
                    end
                    else if (cmd == `CMD_SEVERIFY)
                    begin
                        state_q <= S_VREAD;
                    end
                    else if (cmd == `CMD_PROGRAM)
                    begin
                        state_q <= S_PREP;
                    end
                    else
                    begin
                        addr_q <= a16 & `SECTOR_MASK;
                        state_q <= S_ERASE;
                    end
                end
                S_PREP:
                begin
                    state_q <= vfy_q ? S_VREAD : S_PROG;
                end
                S_PROG:
                begin
                    if (arr_rsp_i.ack)
                    begin
                        state_q <= S_PREP;
                        if ({1'b0, widx_q} == nprog - 3'h1)
                        begin
                            widx_q <= 2'h0;
                            addr_q <= base_q;
                            vfy_q <= 1'b1;
                        end
                        else
                        begin
                            widx_q <= widx_q + 2'h1;
                            addr_q <= addr_q + 16'h0002;
                        end
                    end
                end
                S_ERASE:
                begin
                    if (arr_rsp_i.ack)
                    begin
                        left_q <= `SECTOR_WORDS;
                        state_q <= S_VREAD;
                    end
                end
                S_VREAD:
                begin
                    if (arr_rsp_i.ack)
                    begin
                        addr_q <= addr_q + 16'h0002;
                        if (vfy_q)
                        begin
                            widx_q <= widx_q + 2'h1;
                            state_q <= ({1'b0, widx_q} == nprog - 3'h1) ?
                                       S_DONE : S_PREP;
                        end
                        else
                        begin
                            left_q <= left_q - 16'h0001;
                            if (left_q == 16'h0001)
                            begin
                                state_q <= S_DONE;
                            end
                        end
                    end
                end
                S_DONE:
                begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            arr_cmd_o <= '0;
        end
        else if (ce_i)
        begin
            arr_cmd_o.valid <= (state_q == S_PROG || state_q == S_ERASE ||
                                state_q == S_VREAD) && !arr_rsp_i.ack;
            arr_cmd_o.op <= (state_q == S_PROG) ? OP_PROG :
                            (state_q == S_ERASE) ? OP_ERASE : OP_READ;
            arr_cmd_o.addr <= {blk, addr_q};
            arr_cmd_o.wdata <= mem_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags.

    assign vrd_ack = state_q == S_VREAD && arr_rsp_i.ack;
    assign expect_w = vfy_q ? mem_rdata : `ERASED_WORD;
    assign set_vs1 = vrd_ack && (arr_rsp_i.rdata != expect_w ||
                     arr_rsp_i.sbe || arr_rsp_i.ded);
    assign set_vs0 = vrd_ack && arr_rsp_i.ded;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            command_complete_flag_q <= 1'b1;
            access_error_flag_q <= 1'b0;
            protection_violation_flag_q <= 1'b0;
            vs1_q <= 1'b0;
            vs0_q <= 1'b0;
        end
        else if (ce_i)
        begin
            if (launch)
            begin
                command_complete_flag_q <= 1'b0;
            end
            else if (state_q == S_DONE)
            begin
                command_complete_flag_q <= 1'b1;
            end
            if (state_q == S_CHECK && chk_acc)
            begin
                access_error_flag_q <= 1'b1;
            end
            else if (wr_stat && reg_wdata_i[`STAT_ACC])
            begin
                access_error_flag_q <= 1'b0;
            end
            if (state_q == S_CHECK && !chk_acc && prot_c)
            begin
                protection_violation_flag_q <= 1'b1;
            end
            else if (wr_stat && reg_wdata_i[`STAT_FPV])
            begin
                protection_violation_flag_q <= 1'b0;
            end
            if (set_vs1)
            begin
                vs1_q <= 1'b1;
            end
            else if (launch)
            begin
                vs1_q <= 1'b0;
            end
            if (set_vs0)
            begin
                vs0_q <= 1'b1;
            end
            else if (launch)
            begin
                vs0_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            df_margin_o <= `MARGIN_RST;
            pf_margin_o <= `MARGIN_RST;
        end
        else if (ce_i && state_q == S_CHECK && !chk_acc &&
                 cmd == `CMD_FMARGIN)
        begin
            if (blk == `DF_BLK)
            begin
                df_margin_o <= a16[2:0];
            end
            else
            begin
                pf_margin_o <= a16[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software registers, interrupt and read port.

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            idx_q <= 3'h0;
            cfg_q <= `CFG_RST;
            prot_q <= `PROT_RST;
            mask_q <= `MASK_RST;
        end
        else if (ce_i && reg_wr_i)
        begin
            if (reg_addr_i == `REG_INDEX && command_complete_flag_q)
            begin
                idx_q <= reg_wdata_i[2:0];
            end
            if (reg_addr_i == `REG_CFG)
            begin
                cfg_q <= reg_wdata_i[1:0];
            end
            if (reg_addr_i == `REG_PROT)
            begin
                prot_q <= reg_wdata_i;
            end
            if (reg_addr_i == `REG_IRQ_MASK)
            begin
                mask_q <= reg_wdata_i[2:0];
            end
        end
    end

    assign irq_set = {state_q == S_CHECK && !chk_acc && prot_c,
                      state_q == S_CHECK && chk_acc, state_q == S_DONE};

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            irq_stat_q <= 3'h0;
            irq_o <= 1'b0;
        end
        else if (ce_i)
        begin
            irq_stat_q <= irq_set | (irq_stat_q &
                ~((reg_wr_i && reg_addr_i == `REG_IRQ_STAT) ?
                  reg_wdata_i[2:0] : 3'h0));
            irq_o <= |(irq_stat_q & mask_q);
        end
    end

    always_comb
    begin
        rd_mux = 16'h0000;
        unique case (reg_addr_i)
            `REG_STAT:
            begin
                rd_mux[`STAT_COMMAND_COMPLETE_FLAG] = command_complete_flag_q;
                rd_mux[`STAT_ACC] = access_error_flag_q;
                rd_mux[`STAT_FPV] = protection_violation_flag_q;
                rd_mux[`STAT_VS1] = vs1_q;
                rd_mux[`STAT_VS0] = vs0_q;
            end
            `REG_INDEX: rd_mux = {13'h0000, idx_q};
            `REG_CFG: rd_mux = {14'h0000, cfg_q};
            `REG_PROT: rd_mux = prot_q;
            `REG_MARGIN: rd_mux = {10'h000, pf_margin_o, df_margin_o};
            `REG_IRQ_STAT: rd_mux = {13'h0000, irq_stat_q};
            `REG_IRQ_MASK: rd_mux = {13'h0000, mask_q};
            default: rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            reg_rdata_o <= 16'h0000;
        end
        else if (ce_i)
        begin
            reg_rdata_o <= reg_rd_i ? rd_mux : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i || !ce_i);

    sequence s_check(logic [7:0] c);
        ce_i && state_q == S_CHECK && cmd == c;
    endsequence
    sequence s_finish;
        state_q == S_DONE ##1 command_complete_flag_q;
    endsequence

    property p_fm_mode;
        s_check(`CMD_FMARGIN) and !cfg_q[`CFG_SPECIAL] |=> access_error_flag_q;
    endproperty
    a_fm_mode: assert property (p_fm_mode) else $error("fm mode");
    property p_fm_nofpv;
        s_check(`CMD_FMARGIN) and !protection_violation_flag_q |=> !protection_violation_flag_q ##1 !protection_violation_flag_q;
    endproperty
    a_fm_nofpv: assert property (p_fm_nofpv) else $error("fm fpv");
    property p_secure;
        ce_i && state_q == S_CHECK && cfg_q[`CFG_SECURE] &&
            cmd != `CMD_FMARGIN |=> access_error_flag_q && state_q == S_DONE;
    endproperty
    a_secure: assert property (p_secure) else $error("secure");
    property p_sev_idx;
        s_check(`CMD_SEVERIFY) and idx_q != `IDX_SEVERIFY |=> access_error_flag_q;
    endproperty
    a_sev_idx: assert property (p_sev_idx) else $error("sev idx");
    property p_odd;
        ce_i && state_q == S_CHECK && a16[0] && cmd != `CMD_FMARGIN |=>
            access_error_flag_q ##1 command_complete_flag_q;
    endproperty
    a_odd: assert property (p_odd) else $error("odd addr");
    property p_prog_idx;
        s_check(`CMD_PROGRAM) and idx_q > `IDX_PROG_MAX |=> access_error_flag_q;
    endproperty
    a_prog_idx: assert property (p_prog_idx) else $error("prog idx");
    property p_prot;
        ce_i && state_q == S_CHECK && !chk_acc && prot_c |=>
            protection_violation_flag_q && !arr_cmd_o.valid ##1 command_complete_flag_q;
    endproperty
    a_prot: assert property (p_prot) else $error("protect");
    property p_ded;
        ce_i && vrd_ack && arr_rsp_i.ded |=> vs1_q && vs0_q;
    endproperty
    a_ded: assert property (p_ded) else $error("ded");
    property p_done;
        ce_i && state_q == S_DONE |-> s_finish;
    endproperty
    a_done: assert property (p_done) else $error("done");
endmodule

/* File: core/dflash_map.svh */
// Register offsets, field positions, reset values and command constants.
`ifndef DFLASH_MAP_SVH
`define DFLASH_MAP_SVH
`define REG_STAT 4'h0
`define REG_INDEX 4'h1
`define REG_OBJECT 4'h2
`define REG_CFG 4'h3
`define REG_PROT 4'h4
`define REG_MARGIN 4'h5
`define REG_IRQ_STAT 4'h6
`define REG_IRQ_MASK 4'h7
`define STAT_COMMAND_COMPLETE_FLAG 7
`define STAT_ACC 5
`define STAT_FPV 4
`define STAT_VS1 1
`define STAT_VS0 0
`define CFG_SPECIAL 0
`define CFG_SECURE 1
`define IRQ_DONE 0
`define IRQ_ACC 1
`define IRQ_FPV 2
`define CFG_RST 2'h0
`define PROT_RST 16'hFFFF
`define MASK_RST 3'h0
`define MARGIN_RST 3'h0
`define CMD_FMARGIN 8'h0E
`define CMD_SEVERIFY 8'h10
`define CMD_PROGRAM 8'h11
`define CMD_ERASE 8'h12
`define IDX_FMARGIN 3'h1
`define IDX_SEVERIFY 3'h2
`define IDX_PROG_MIN 3'h2
`define IDX_PROG_MAX 3'h5
`define IDX_ERASE 3'h1
`define IDX_DATA0 3'h2
`define DF_BLK 2'h0
`define PF_BLK 2'h3
`define DF_BYTES 17'h01000
`define SECTOR_MASK 16'hFF00
`define SECTOR_BYTES 17'h00100
`define SECTOR_WORDS 16'h0080
`define MARGIN_MAX 16'h0004
`define ERASED_WORD 16'hFFFF
`endif

/* File: core/dflash_pkg.sv */
// Types shared by the command sequencer and its testbench.
package dflash_pkg;
    typedef enum {
        S_IDLE, S_FETCH, S_CHECK, S_PREP, S_PROG, S_ERASE, S_VREAD, S_DONE
    } state_t;
    typedef enum logic [1:0] {
        OP_READ, OP_PROG, OP_ERASE
    } arr_op_t;
    typedef struct packed {
        logic valid;
        arr_op_t op;
        logic [17:0] addr;
        logic [15:0] wdata;
    } arr_cmd_t;
    typedef struct packed {
        logic ack;
        logic [15:0] rdata;
        logic sbe;
        logic ded;
    } arr_rsp_t;
endpackage

/* File: tb/testbench.sv */
// Self-checking bench for the data flash command sequencer.
`timescale 1ns/1ps
`include "dflash_map.svh"
module testbench;
    import dflash_pkg::*;
    logic clk_i = 0, rst_n_i = 0, ce_i = 1, reg_wr_i = 0, reg_rd_i = 0;
    logic irq_o, ok, sec = 0, sbe = 0, ded = 0;
    logic [3:0] reg_addr_i = 0;
    logic [15:0] reg_wdata_i = 0, reg_rdata_o, rdv, a, s, pr, old, e;
    logic [2:0] df_margin_o, pf_margin_o, lv, dm = 0, pm = 0;
    logic [1:0] blk;
    logic [15:0] mem [0:2047];
    logic [15:0] cw [0:5];
    arr_cmd_t arr_cmd_o;
    arr_rsp_t arr_rsp_i = '0;
    int num_errors = 0, check_count = 0, cyc = 0, dly = 0, m, n, c;

    dflash_command_sequencer uut (.clk_i, .rst_n_i, .ce_i, .reg_addr_i,
        .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o,
        .arr_cmd_o, .arr_rsp_i, .df_margin_o, .pf_margin_o);

    initial forever #12.5 clk_i = ~clk_i;

    always @(posedge clk_i)
        if (++cyc == 90000)
        begin
            num_errors++;
            tally_and_finish();
        end

    ////////////////////////////////////////////////////////////////
    // The array answers after a random delay and scrambles idle data.
    always @(posedge clk_i)
        if (dly == 0 && arr_cmd_o.valid && !arr_rsp_i.ack)
        begin
            arr_rsp_i <= {1'b1, mem[arr_cmd_o.addr[11:1]], sbe, ded};
            dly <= $urandom % 4;
            if (arr_cmd_o.op == OP_PROG)
                mem[arr_cmd_o.addr[11:1]] <= arr_cmd_o.wdata;
            if (arr_cmd_o.op == OP_ERASE)
                for (int i = 0; i < 128; i++)
                    mem[{arr_cmd_o.addr[11:8], i[6:0]}] <= 16'hFFFF;
        end
        else
        begin
            arr_rsp_i <= {1'b0, ~arr_rsp_i.rdata, 2'b11};
            dly <= (dly > 0) ? dly - 1 : 0;
        end

    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic acc(input logic w, input logic [3:0] ad, logic [15:0] d);
        reg_addr_i <= ad;
        reg_wdata_i <= d;
        reg_wr_i <= w;
        reg_rd_i <= !w;
        @(posedge clk_i);
        reg_wr_i <= 0;
        reg_rd_i <= 0;
        #1 rdv = reg_rdata_o;
        @(posedge clk_i);
    endtask

    task automatic run(input logic [2:0] ix, input logic [15:0] ex);
        for (int i = 0; i < 6; i++)
        begin
            acc(1, `REG_INDEX, 16'(i));
            acc(1, `REG_OBJECT, cw[i]);
        end
        acc(1, `REG_INDEX, {13'h0, ix});
        acc(1, `REG_STAT, 16'h00B0);
        rdv = 0;
        for (int i = 0; i < 3000 && !rdv[7]; i++)
            acc(0, `REG_STAT, 0);
        chk(rdv & 16'h00B3, ex | 16'h0080);
    endtask

    function automatic logic [15:0] xp(logic [15:0] st, int nb, logic ph, mis);
        if (!ok || blk != 0 || sec || st[0] || int'(st) + nb > 4096)
            return 16'h0020;
        return ph ? 16'h0010 : {14'h0, sbe | ded | mis, ded};
    endfunction

    function automatic logic dirty(logic [15:0] st, int cnt);
        for (int i = 0; i < cnt; i++)
            if (mem[st[11:1] + i] !== 16'hFFFF) return 1;
        return 0;
    endfunction

    task automatic tally_and_finish();
        $display("Checks %0d, errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(32'hE155));
        for (int i = 0; i < 2048; i++)
            mem[i] = 16'($urandom);
        repeat (12) @(posedge clk_i);
        chk(16'({df_margin_o, pf_margin_o, irq_o}), 16'h0);
        rst_n_i <= 1;
        @(posedge clk_i);
        acc(0, `REG_STAT, 0);
        chk(rdv & 16'h00B3, 16'h0080);
        acc(0, `REG_PROT, 0);
        chk(rdv, 16'hFFFF);
        ce_i <= 0;
        acc(1, `REG_IRQ_MASK, 16'h0007);
        ce_i <= 1;
        acc(0, `REG_IRQ_MASK, 0);
        chk(rdv, 16'h0);
        for (int i = 8; i < 16; i++)
        begin
            acc(0, 4'(i), 0);
            chk(rdv, 16'h0);
        end
        for (int k = 0; k < 16; k++)
        begin
            blk = 2'($urandom % 4);
            lv = 3'(k % 6);
            acc(1, `REG_CFG, 16'(k != 0));
            cw[0] = {`CMD_FMARGIN, 6'h0, blk};
            cw[1] = {13'h0, lv};
            ok = k > 1 && (blk == 0 || blk == 3) && lv < 5;
            run(k == 1 ? 3'h2 : `IDX_FMARGIN,
                ok ? 16'h0 : 16'h0020);
            if (ok && blk == 0) dm = lv;
            if (ok && blk == 3) pm = lv;
            acc(0, `REG_MARGIN, 0);
            chk(rdv & 16'h003F, {10'h0, pm, dm});
            chk({10'h0, pf_margin_o, df_margin_o}, {10'h0, pm, dm});
        end
        cw[0] = 16'h3C00;
        run(`IDX_FMARGIN, 16'h0020);
        chk(16'(irq_o), 16'h0);
        acc(1, `REG_IRQ_MASK, 16'h0001);
        acc(0, `REG_IRQ_STAT, 0);
        chk(rdv & 16'h0007, 16'h0003);
        chk(16'(irq_o), 16'h0001);
        acc(1, `REG_IRQ_STAT, 16'h0001);
        acc(1, `REG_IRQ_MASK, 16'h0000);
        chk(16'(irq_o), 16'h0);
        for (int k = 0; k < 30; k++)
        begin
            m = $urandom % 8;
            n = 1 + $urandom % 4;
            a = 16'($urandom % 512) << 3;
            blk = (m == 2) ? 2'(1 + $urandom % 3) : 2'h0;
            pr = ($urandom % 2) ? 16'h0800 : 16'hFFFF;
            sec = (m == 5);
            sbe = (m == 6);
            ded = (m == 7);
            ok = (m != 3);
            if (m == 1) a[0] = 1'b1;
            if (m == 4) a = 16'(4098 - 2 * n);
            acc(1, `REG_PROT, pr);
            acc(1, `REG_CFG, {14'h0, sec, 1'b0});
            cw[0] = {`CMD_ERASE, 6'h0, blk};
            cw[1] = a;
            old = mem[a[11:1]];
            e = xp(a, 2, a >= pr, 0);
            run(ok ? `IDX_ERASE : 3'h2, e);
            chk(mem[a[11:1]], e[5:4] ? old : 16'hFFFF);
            cw[0] = {`CMD_PROGRAM, 6'h0, blk};
            for (int i = 2; i < 6; i++)
                cw[i] = 16'($urandom) & 16'hFFFE;
            old = mem[a[11:1]];
            e = xp(a, 2 * n, a >= pr, 0);
            run(ok ? 3'(n + 1) : 3'(k % 2 ? 1 : 6), e);
            chk(mem[a[11:1]], e[5:4] ? old : cw[2]);
            if (e[5:4] == 0 && n < 4)
                chk(mem[a[11:1] + 11'(n)], 16'hFFFF);
            s = (k % 2) ? a : a + 16'(2 * n);
            c = (m == 4) ? n : 1 + $urandom % 32;
            cw[0] = {`CMD_SEVERIFY, 6'h0, blk};
            cw[1] = s;
            cw[2] = ok ? 16'(c) : 16'h0;
            e = xp(s, 2 * c, 0, dirty(s, c));
            run(ok || k % 2 == 0 ? `IDX_SEVERIFY : 3'h1, e);
        end
        tally_and_finish();
    end
endmodule
